/* File: ssar_pkg.sv */
// Contract
// - Up-to-speed limit programmable 1 to 300 s, default 20 s.
// - Stall flagged when up-to-speed not reached before up-to-speed timer expiry.
// - Up to speed only after ramp elapsed and current below 175 percent of MOTOR_FULL_LOAD_CURRENT.
// - Stall raises the up-to-speed fault with fault code 01.
// - Limit never enlarged; ramp longer than limit always ends in fault.
// - Voltage-ramp mode applies full voltage when up-to-speed timer expires.
// - Star-delta starter forces delta transition at timer expiry if not done.
// - Five start modes, current ramp default; mode picks the ramped quantity; here every mode ramps the same current set.
// - Tach mode uses initial and maximum current as current limits.
// - Ramp runs initial to maximum over ramp time 0 to 300 s, default 15 s.
// - After ramp end, hold maximum current until speed, timer expiry or overload.
// - Start begins at initial current, 50 to 600 percent, default 100 percent.
// - Maximum current 100 to 800 percent, default 600, ramp end and cap.
// - Second ramp active selects second parameter set with the same ranges.
package ssar_pkg;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLOCK_HZ        = 100_000_000;
	localparam int TICK_MS         = 10;
	localparam int TICK_CYCLES     = CLOCK_HZ / 1000 * TICK_MS;
	localparam int TICKS_PER_SEC   = 1000 / TICK_MS;
	// ----------------------------------------------------------------
	// Parameter ranges and defaults
	// ----------------------------------------------------------------
	localparam logic [8:0] UTS_MIN_S    = 9'h001;
	localparam logic [8:0] UTS_MAX_S    = 9'h12C;
	localparam logic [8:0] UTS_DEF_S    = 9'h014;
	localparam logic [8:0] RAMP_MAX_S   = 9'h12C;
	localparam logic [8:0] RAMP_DEF_S   = 9'h00F;
	localparam logic [9:0] INIT_MIN_PCT = 10'h032;
	localparam logic [9:0] INIT_MAX_PCT = 10'h258;
	localparam logic [9:0] INIT_DEF_PCT = 10'h064;
	localparam logic [9:0] MAXC_MIN_PCT = 10'h064;
	localparam logic [9:0] MAXC_MAX_PCT = 10'h320;
	localparam logic [9:0] MAXC_DEF_PCT = 10'h258;
	localparam logic [9:0] UTS_CUR_PCT  = 10'h0AF;
	localparam logic [9:0] FULL_PCT     = 10'h064;
	localparam logic [7:0] FAULT_UTS    = 8'h01;
	localparam logic [7:0] FAULT_NONE   = 8'h00;

	typedef enum logic [2:0] {
		MODE_VOLTAGE,
		MODE_CURRENT,
		MODE_TORQUE,
		MODE_POWER,
		MODE_TACH
	} ssar_mode_e;

	typedef struct packed {
		logic [8:0] rampTime;
		logic [9:0] initialCurrent;
		logic [9:0] maximumCurrent;
	} ssar_set_s;

	localparam ssar_set_s SET_DEFAULT = '{RAMP_DEF_S, INIT_DEF_PCT, MAXC_DEF_PCT};
endpackage : ssar_pkg

/* File: ssar_tick.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Fixed-period tick divider
// ----------------------------------------------------------------
module ssar_tick #(
	parameter int CYCLES = ssar_pkg::TICK_CYCLES
) (
	input  wire logic clock,
	input  wire logic arst_n,
	output logic      tick
);
	logic [31:0] cnt_q;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q <= 32'h0;
			tick  <= 1'b0;
		end else if (cnt_q == 32'(CYCLES - 1)) begin
			cnt_q <= 32'h0;
			tick  <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 32'h1;
			tick  <= 1'b0;
		end
	end
endmodule : ssar_tick

/* File: soft_start_accel_ramp_control.sv */
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module ssar_soft_start_accel_ramp_control #(
	parameter int TICK_CYCLES   = ssar_pkg::TICK_CYCLES,
	parameter int TICKS_PER_SEC = ssar_pkg::TICKS_PER_SEC
) (
	input  wire logic                clock,
	input  wire logic                arst_n,
	input  wire logic                startCmd,
	input  wire logic                stopCmd,
	input  wire logic                overloadTrip,
	input  wire logic                secondRampActive,
	input  wire logic                fullSpeedDetect,
	input  wire logic [9:0]          measuredCurrentPct,
	input  wire logic                starDeltaTransitionDone,
	input  wire logic                regWrite,
	input  wire logic                regRead,
	input  wire logic [3:0]          regAddr,
	input  wire logic [31:0]         regWdata,
	output logic      [31:0]         regRdata,
	output logic                     irq,
	output logic      [9:0]          rampReference,
	output logic      [9:0]          currentLimit,
	output logic                     fullVoltage,
	output logic                     deltaTransition,
	output logic                     up_to_speed,
	output logic                     upToSpeedFault,
	output logic      [7:0]          faultCode,
	output logic                     starting
);
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [3:0] A_MODE   = 4'h0;
	localparam logic [3:0] A_UTS    = 4'h1;
	localparam logic [3:0] A_SET1   = 4'h2;
	localparam logic [3:0] A_SET2   = 4'h3;
	localparam logic [3:0] A_STAT   = 4'h4;
	localparam logic [3:0] A_MASK   = 4'h5;
	localparam logic [3:0] A_STATE  = 4'h6;

	typedef enum logic [1:0] {ST_IDLE, ST_RAMP, ST_HOLD, ST_RUN} ssar_state_e;

	// Pin inputs are synchronised: two stages before any use
	logic [1:0] syncStart, syncStop, syncOl, syncSecond, syncSpeed, syncSd;
	logic       startS, stopS, olS, secondS, speedS, sdS;
	logic [9:0] curA_q, curB_q;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			syncStart  <= 2'h0;
			syncStop   <= 2'h0;
			syncOl     <= 2'h0;
			syncSecond <= 2'h0;
			syncSpeed  <= 2'h0;
			syncSd     <= 2'h0;
			curA_q     <= 10'h000;
			curB_q     <= 10'h000;
		end else begin
			syncStart  <= {syncStart[0], startCmd};
			syncStop   <= {syncStop[0], stopCmd};
			syncOl     <= {syncOl[0], overloadTrip};
			syncSecond <= {syncSecond[0], secondRampActive};
			syncSpeed  <= {syncSpeed[0], fullSpeedDetect};
			syncSd     <= {syncSd[0], starDeltaTransitionDone};
			curA_q     <= measuredCurrentPct;
			curB_q     <= curA_q;
		end
	end
	assign startS  = syncStart[1];
	assign stopS   = syncStop[1];
	assign olS     = syncOl[1];
	assign secondS = syncSecond[1];
	assign speedS  = syncSpeed[1];
	assign sdS     = syncSd[1];

	// ----------------------------------------------------------------
	// Tick
	// ----------------------------------------------------------------
	logic tick;
	ssar_tick #(.CYCLES(TICK_CYCLES)) u_tick (
		.clock  (clock),
		.arst_n (arst_n),
		.tick   (tick)
	);

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	ssar_pkg::ssar_mode_e mode_q;
	logic                 starDelta_q;
	logic [8:0]           utsLimit_q;
	logic [9:0]           fla_q;
	ssar_pkg::ssar_set_s  set1_q, set2_q;
	logic [1:0]           stat_q, mask_q;
	logic                 evFault, evUts;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			mode_q      <= ssar_pkg::MODE_CURRENT;
			starDelta_q <= 1'b0;
			utsLimit_q  <= ssar_pkg::UTS_DEF_S;
			fla_q       <= ssar_pkg::FULL_PCT;
			set1_q      <= ssar_pkg::SET_DEFAULT;
			set2_q      <= ssar_pkg::SET_DEFAULT;
			mask_q      <= 2'h0;
		end else if (regWrite) begin
			if (regAddr == A_MODE) begin
				if (regWdata[2:0] <= 3'(ssar_pkg::MODE_TACH))
					mode_q <= ssar_pkg::ssar_mode_e'(regWdata[2:0]);
				starDelta_q <= regWdata[4];
			end else if (regAddr == A_UTS) begin
				// Out-of-range limits are clamped, never silently widened later
				if (regWdata[8:0] < ssar_pkg::UTS_MIN_S)
					utsLimit_q <= ssar_pkg::UTS_MIN_S;
				else if (regWdata[8:0] > ssar_pkg::UTS_MAX_S)
					utsLimit_q <= ssar_pkg::UTS_MAX_S;
				else
					utsLimit_q <= regWdata[8:0];
				fla_q <= regWdata[25:16];
			end else if (regAddr == A_SET1) begin
				set1_q <= clampSet(regWdata[28:0]);
			end else if (regAddr == A_SET2) begin
				set2_q <= clampSet(regWdata[28:0]);
			end else if (regAddr == A_MASK) begin
				mask_q <= regWdata[1:0];
			end
		end
	end

	function automatic ssar_pkg::ssar_set_s clampSet(input logic [28:0] w);
		ssar_pkg::ssar_set_s s;
		s = w;
		if (s.rampTime > ssar_pkg::RAMP_MAX_S) s.rampTime = ssar_pkg::RAMP_MAX_S;
		if (s.initialCurrent < ssar_pkg::INIT_MIN_PCT) s.initialCurrent = ssar_pkg::INIT_MIN_PCT;
		if (s.initialCurrent > ssar_pkg::INIT_MAX_PCT) s.initialCurrent = ssar_pkg::INIT_MAX_PCT;
		if (s.maximumCurrent < ssar_pkg::MAXC_MIN_PCT) s.maximumCurrent = ssar_pkg::MAXC_MIN_PCT;
		if (s.maximumCurrent > ssar_pkg::MAXC_MAX_PCT) s.maximumCurrent = ssar_pkg::MAXC_MAX_PCT;
		return s;
	endfunction : clampSet

	// ----------------------------------------------------------------
	// Start sequencer
	// ----------------------------------------------------------------
	ssar_state_e         state_q;
	ssar_pkg::ssar_set_s act_q;
	logic [31:0]         rampTicks_q, utsTicks_q;
	logic [31:0]         rampLen, utsLen;
	logic                rampDone, utsExpire, atSpeed;

	assign rampLen   = 32'(act_q.rampTime) * 32'(TICKS_PER_SEC);
	assign utsLen    = 32'(utsLimit_q) * 32'(TICKS_PER_SEC);
	assign rampDone  = rampTicks_q >= rampLen;
	assign utsExpire = tick && (utsTicks_q + 32'h1 >= utsLen);
	// Current settled below 175 percent of full load
	assign atSpeed   = rampDone && speedS &&
	                   (20'(curB_q) * 20'h64 < 20'(ssar_pkg::UTS_CUR_PCT) * 20'(fla_q));

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_q     <= ST_IDLE;
			act_q       <= ssar_pkg::SET_DEFAULT;
			rampTicks_q <= 32'h0;
			utsTicks_q  <= 32'h0;
			evFault     <= 1'b0;
			evUts       <= 1'b0;
		end else begin
			evFault <= 1'b0;
			evUts   <= 1'b0;
			if (stopS || olS) begin
				state_q <= ST_IDLE;
			end else begin
				case (state_q)
					ST_IDLE: begin
						if (startS && !upToSpeedFault) begin
							act_q       <= secondS ? set2_q : set1_q;
							rampTicks_q <= 32'h0;
							utsTicks_q  <= 32'h0;
							state_q     <= ST_RAMP;
						end
					end
					ST_RAMP, ST_HOLD: begin
						if (tick) begin
							utsTicks_q <= utsTicks_q + 32'h1;
							if (!rampDone) rampTicks_q <= rampTicks_q + 32'h1;
						end
						if (atSpeed) begin
							state_q <= ST_RUN;
							evUts   <= 1'b1;
						end else if (utsExpire) begin
							state_q <= ST_IDLE;
							evFault <= 1'b1;
						end else if (rampDone) begin
							state_q <= ST_HOLD;
						end
					end
					ST_RUN: begin
						if (!startS) state_q <= ST_IDLE;
					end
					default: state_q <= ST_IDLE;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Reference and outputs
	// ----------------------------------------------------------------
	logic [9:0] refNow, lowEnd, highEnd;
	logic [41:0] span;

	always_comb begin
		// Every mode ramps the same set; the mode picks the limit source, and voltage mode also gets full voltage
		lowEnd  = act_q.initialCurrent;
		highEnd = act_q.maximumCurrent;
		span = 42'h0;
		if (rampDone || highEnd <= lowEnd) begin
			refNow = highEnd;
		end else begin
			span   = 42'(highEnd - lowEnd) * 42'(rampTicks_q);
			refNow = lowEnd + 10'(span / 42'(rampLen));
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rampReference   <= 10'h000;
			currentLimit    <= 10'h000;
			fullVoltage     <= 1'b0;
			deltaTransition <= 1'b0;
			up_to_speed     <= 1'b0;
			starting        <= 1'b0;
		end else begin
			starting      <= (state_q == ST_RAMP) || (state_q == ST_HOLD);
			up_to_speed   <= state_q == ST_RUN;
			rampReference <= (state_q == ST_IDLE) ? 10'h000 : refNow;
			currentLimit  <= (state_q == ST_IDLE) ? 10'h000 :
			                 (mode_q == ssar_pkg::MODE_TACH) ? refNow : highEnd;
			if (state_q == ST_IDLE) begin
				fullVoltage     <= 1'b0;
				deltaTransition <= 1'b0;
			end else begin
				if (utsExpire || state_q == ST_RUN) begin
					if (mode_q == ssar_pkg::MODE_VOLTAGE) fullVoltage <= 1'b1;
					if (starDelta_q && !sdS) deltaTransition <= 1'b1;
				end
			end
		end
	end

	// Fault latches until a start is removed and a stop is given
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			upToSpeedFault <= 1'b0;
			faultCode      <= ssar_pkg::FAULT_NONE;
		end else if (evFault) begin
			upToSpeedFault <= 1'b1;
			faultCode      <= ssar_pkg::FAULT_UTS;
		end else if (stopS && !startS) begin
			upToSpeedFault <= 1'b0;
			faultCode      <= ssar_pkg::FAULT_NONE;
		end
	end

	// ----------------------------------------------------------------
	// Interrupts and read port
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			stat_q <= 2'h0;
			irq    <= 1'b0;
		end else begin
			// Set wins over write-one-to-clear
			stat_q <= (stat_q & ~((regWrite && regAddr == A_STAT) ? regWdata[1:0] : 2'h0))
			          | {evUts, evFault};
			irq    <= |(stat_q & mask_q);
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			regRdata <= 32'h0;
		end else if (regRead) begin
			if (regAddr == A_MODE) regRdata <= {27'h0, starDelta_q, 1'b0, 3'(mode_q)};
			else if (regAddr == A_UTS) regRdata <= {6'h0, fla_q, 7'h0, utsLimit_q};
			else if (regAddr == A_SET1) regRdata <= {3'h0, set1_q};
			else if (regAddr == A_SET2) regRdata <= {3'h0, set2_q};
			else if (regAddr == A_STAT) regRdata <= {30'h0, stat_q};
			else if (regAddr == A_MASK) regRdata <= {30'h0, mask_q};
			else if (regAddr == A_STATE) regRdata <= {6'h0, faultCode, upToSpeedFault,
			                                           fullVoltage, 4'h0, refNow, 2'(state_q)};
			else regRdata <= 32'h0;
		end else begin
			regRdata <= 32'h0;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_fault_code;
		@(posedge clock) disable iff (!arst_n) upToSpeedFault |-> faultCode == ssar_pkg::FAULT_UTS;
	endproperty
	a_fault_code: assert property (p_fault_code) else $error("fault code wrong");

	property p_fault_cause;
		@(posedge clock) disable iff (!arst_n) $rose(upToSpeedFault) |-> $past(evFault);
	endproperty
	a_fault_cause: assert property (p_fault_cause) else $error("fault without stall");

	property p_speed_needs_ramp;
		@(posedge clock) disable iff (!arst_n) $rose(up_to_speed) |-> $past(rampDone, 2);
	endproperty
	a_speed_needs_ramp: assert property (p_speed_needs_ramp) else $error("speed before ramp");

	property p_ramp_long;
		@(posedge clock) disable iff (!arst_n) state_q == ST_RUN |-> rampLen <= utsLen;
	endproperty
	a_ramp_long: assert property (p_ramp_long) else $error("run with ramp over limit");

	property p_limit_range;
		@(posedge clock) disable iff (!arst_n)
			utsLimit_q >= ssar_pkg::UTS_MIN_S && utsLimit_q <= ssar_pkg::UTS_MAX_S;
	endproperty
	a_limit_range: assert property (p_limit_range) else $error("limit out of range");

	property p_hold_max;
		@(posedge clock) disable iff (!arst_n)
			state_q == ST_HOLD && !stopS ##1 1'b1 |-> rampReference == $past(highEnd);
	endproperty
	a_hold_max: assert property (p_hold_max) else $error("hold not at maximum");

	property p_fullv;
		@(posedge clock) disable iff (!arst_n)
			fullVoltage |-> mode_q == ssar_pkg::MODE_VOLTAGE || $past(mode_q) == ssar_pkg::MODE_VOLTAGE;
	endproperty
	a_fullv: assert property (p_fullv) else $error("full voltage outside voltage mode");

	property p_delta;
		@(posedge clock) disable iff (!arst_n) $rose(deltaTransition) |-> $past(starDelta_q);
	endproperty
	a_delta: assert property (p_delta) else $error("delta without star-delta");

	property p_ramp_range;
		@(posedge clock) disable iff (!arst_n)
			set1_q.rampTime <= ssar_pkg::RAMP_MAX_S && set2_q.maximumCurrent <= ssar_pkg::MAXC_MAX_PCT;
	endproperty
	a_ramp_range: assert property (p_ramp_range) else $error("set out of range");
endmodule : ssar_soft_start_accel_ramp_control

/* File: ssar_motor_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Power stage and motor current feedback model
// ----------------------------------------------------------------
module ssar_motor_model (
	input  wire logic       clock,
	input  wire logic       arst_n,
	input  wire logic       starting,
	input  wire logic       atSpeed,
	input  wire logic       deltaTransition,
	input  wire logic       fast,
	input  wire logic [9:0] currentLimit,
	output logic            fullSpeedDetect,
	output logic            starDeltaTransitionDone,
	output logic      [9:0] measuredCurrentPct
);
	logic [15:0] runCount_q;
	logic        motorRun;

	assign motorRun = starting | atSpeed;

	// A slow load never reaches speed and keeps drawing the full limit
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			runCount_q      <= 16'h0000;
			fullSpeedDetect <= 1'b0;
		end else if (!motorRun) begin
			runCount_q      <= 16'h0000;
			fullSpeedDetect <= 1'b0;
		end else begin
			runCount_q      <= runCount_q + 16'h0001;
			fullSpeedDetect <= fast && (runCount_q >= 16'h01F4);
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			measuredCurrentPct <= 10'h000;
		end else if (!motorRun) begin
			measuredCurrentPct <= 10'h000;
		end else if (fullSpeedDetect) begin
			measuredCurrentPct <= 10'h050;
		end else begin
			measuredCurrentPct <= currentLimit;
		end
	end

	// Contactor reports the change only after it was commanded
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			starDeltaTransitionDone <= 1'b0;
		end else if (!motorRun) begin
			starDeltaTransitionDone <= 1'b0;
		end else if (deltaTransition) begin
			starDeltaTransitionDone <= 1'b1;
		end
	end
endmodule : ssar_motor_model

/* File: soft_start_accel_ramp_control_tb.sv */
`timescale 1ns/1ps
module soft_start_accel_ramp_control_tb;
	// Tick is free running, so every start-relative time is uncertain by one tick
	localparam int TICK = 1000;
	localparam int SEC  = 10 * TICK;
	logic        clock, arst_n, startCmd, stopCmd, overloadTrip, secondRampActive, fast;
	logic        regWrite, regRead, irq, fullVoltage, deltaTransition, up_to_speed;
	logic        upToSpeedFault, starting, fullSpeedDetect, sdDone, sawFullV, sawDelta;
	logic [3:0]  regAddr;
	logic [31:0] regWdata, regRdata, rd;
	logic [9:0]  measuredCurrentPct, rampReference, currentLimit;
	logic [7:0]  faultCode;
	int          badCount, nCompared, cyc, t0, n;

	ssar_soft_start_accel_ramp_control #(.TICK_CYCLES(1000), .TICKS_PER_SEC(10))
	i_ssar_soft_start_accel_ramp_control (.clock(clock), .arst_n(arst_n), .startCmd(startCmd),
		.stopCmd(stopCmd), .overloadTrip(overloadTrip), .secondRampActive(secondRampActive),
		.fullSpeedDetect(fullSpeedDetect), .measuredCurrentPct(measuredCurrentPct),
		.starDeltaTransitionDone(sdDone), .regWrite(regWrite), .regRead(regRead),
		.regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .irq(irq),
		.rampReference(rampReference), .currentLimit(currentLimit), .fullVoltage(fullVoltage),
		.deltaTransition(deltaTransition), .up_to_speed(up_to_speed),
		.upToSpeedFault(upToSpeedFault), .faultCode(faultCode), .starting(starting));

	ssar_motor_model i_ssar_motor_model (.clock(clock), .arst_n(arst_n), .starting(starting),
		.atSpeed(up_to_speed), .deltaTransition(deltaTransition), .fast(fast),
		.currentLimit(currentLimit), .fullSpeedDetect(fullSpeedDetect),
		.starDeltaTransitionDone(sdDone), .measuredCurrentPct(measuredCurrentPct));

	always #5 clock = ~clock;

	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (fullVoltage === 1'b1) sawFullV <= 1'b1;
		if (deltaTransition === 1'b1) sawDelta <= 1'b1;
	end

	task conclude;
		$display("compared %0d mismatches %0d", nCompared, badCount);
		if (badCount == 0 && nCompared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : conclude

	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		nCompared++;
		if (seen !== exp) begin
			badCount++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		regWrite <= 1'b1;
		regAddr  <= a;
		regWdata <= d;
		@(posedge clock);
		regWrite <= 1'b0;
	endtask : wr

	// Read data stands only in the cycle after the strobe
	task rdr(input logic [3:0] a);
		@(posedge clock);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge clock);
		regRead <= 1'b0;
		#1 rd = regRdata;
	endtask : rdr

	function automatic logic sig(input int k);
		case (k)
			0: return starting;
			1: return up_to_speed;
			2: return upToSpeedFault;
			3: return !irq;
			default: return !starting;
		endcase
	endfunction : sig

	task waitSig(input int k, input int lim);
		n = 0;
		while (sig(k) !== 1'b1 && n < lim) begin
			@(posedge clock);
			n++;
		end
		#1;
		chk("wait bound", n < lim, 1'b1);
	endtask : waitSig

	task startRun;
		@(posedge clock);
		startCmd <= 1'b1;
		waitSig(0, 20);
		t0 = cyc;
		repeat (3) @(posedge clock);
		#1;
	endtask : startRun

	// Stop high with start low also clears a latched fault
	task stopRun;
		@(posedge clock);
		startCmd <= 1'b0;
		stopCmd  <= 1'b1;
		repeat (6) @(posedge clock);
		stopCmd <= 1'b0;
		wr(4'h4, 32'h0000_0003);
		waitSig(3, 5);
	endtask : stopRun

	initial begin
		#900_000;
		badCount++;
		$display("ERROR watchdog expected done seen hang");
		conclude();
	end

	initial begin
		clock = 0; arst_n = 0; startCmd = 0; stopCmd = 0; overloadTrip = 0;
		secondRampActive = 0; fast = 1; regWrite = 0; regRead = 0; regAddr = 4'h0;
		regWdata = 32'h0; badCount = 0; nCompared = 0; cyc = 0; sawFullV = 0; sawDelta = 0;
		repeat (3) @(posedge clock);
		arst_n <= 1'b1;
		// ----------------------------------------------------------------
		// Reset values, modes, clamping, unmapped space
		// ----------------------------------------------------------------
		rdr(4'h0); chk("mode", rd, 32'h0000_0001);
		rdr(4'h1); chk("limit", rd, 32'h0064_0014);
		rdr(4'h2); chk("set1", rd, 32'h00F1_9258);
		rdr(4'h3); chk("set2", rd, 32'h00F1_9258);
		rdr(4'h4); chk("status", rd, 32'h0000_0000);
		rdr(4'hF); chk("unmapped", rd, 32'h0000_0000);
		for (int m = 0; m < 5; m++) begin
			wr(4'h0, 32'(m));
			rdr(4'h0); chk("mode", rd, 32'(m));
		end
		wr(4'h0, 32'h0000_0005);
		rdr(4'h0); chk("mode ignored", rd, 32'h0000_0004);
		wr(4'h1, 32'h0064_01FF);
		rdr(4'h1); chk("limit high", rd, 32'h0064_012C);
		wr(4'h1, 32'h0064_0000);
		rdr(4'h1); chk("limit low", rd, 32'h0064_0001);
		// Limit above ramp time, initial below maximum
		wr(4'h0, 32'h0000_0001);
		wr(4'h1, 32'h0064_0002);
		wr(4'h2, 32'h0011_9190);
		wr(4'h3, 32'h0012_592C);
		wr(4'h5, 32'h0000_0000);
		// ----------------------------------------------------------------
		// Current ramp reaching speed
		// ----------------------------------------------------------------
		startRun();
		chk("init ref", rampReference, 10'h064);
		chk("cap", currentLimit, 10'h190);
		waitSig(1, 2 * SEC);
		chk("speed after ramp", (cyc - t0) >= SEC - TICK, 1'b1);
		chk("end ref", rampReference, 10'h190);
		chk("no fault", upToSpeedFault, 1'b0);
		rdr(4'h4); chk("status speed", rd, 32'h0000_0002);
		chk("masked irq", irq, 1'b0);
		wr(4'h5, 32'h0000_0003);
		repeat (3) @(posedge clock);
		#1 chk("irq", irq, 1'b1);
		stopRun();
		chk("irq cleared", irq, 1'b0);
		// ----------------------------------------------------------------
		// Stall in voltage mode with star-delta starter
		// ----------------------------------------------------------------
		fast <= 1'b0;
		wr(4'h0, 32'h0000_0010);
		sawFullV = 0;
		sawDelta = 0;
		startRun();
		repeat (SEC) @(posedge clock);
		#1 chk("early full voltage", fullVoltage, 1'b0);
		waitSig(2, 2 * SEC);
		chk("expiry time", (cyc - t0) >= 2 * SEC - TICK - 20 && (cyc - t0) <= 2 * SEC + 100, 1'b1);
		chk("fault code", faultCode, 8'h01);
		chk("kick", sawFullV, 1'b1);
		chk("delta", sawDelta, 1'b1);
		rdr(4'h4); chk("status fault", rd[0], 1'b1);
		chk("irq fault", irq, 1'b1);
		stopRun();
		chk("fault cleared", upToSpeedFault, 1'b0);
		chk("code cleared", faultCode, 8'h00);
		// ----------------------------------------------------------------
		// Ramp longer than limit always faults
		// ----------------------------------------------------------------
		fast <= 1'b1;
		wr(4'h0, 32'h0000_0001);
		wr(4'h2, 32'h0031_9190);
		startRun();
		waitSig(2, 3 * SEC);
		chk("long ramp fault", upToSpeedFault, 1'b1);
		chk("never at speed", up_to_speed, 1'b0);
		stopRun();
		// ----------------------------------------------------------------
		// Second set in tach mode
		// ----------------------------------------------------------------
		wr(4'h2, 32'h0011_9190);
		wr(4'h0, 32'h0000_0004);
		secondRampActive <= 1'b1;
		startRun();
		chk("set2 init", rampReference, 10'h096);
		chk("tach limit", currentLimit, 10'h096);
		waitSig(1, 2 * SEC);
		chk("set2 end", rampReference, 10'h12C);
		chk("tach max", currentLimit, 10'h12C);
		stopRun();
		// ----------------------------------------------------------------
		// Hold at maximum then overload
		// ----------------------------------------------------------------
		secondRampActive <= 1'b0;
		fast <= 1'b0;
		wr(4'h0, 32'h0000_0001);
		startRun();
		repeat (SEC + 2000) @(posedge clock);
		#1 chk("hold ref", rampReference, 10'h190);
		chk("hold cap", currentLimit, 10'h190);
		@(posedge clock);
		overloadTrip <= 1'b1;
		waitSig(4, 10);
		chk("overload idle", starting, 1'b0);
		// Overload stays until start is gone, else a fresh start would follow
		stopRun();
		overloadTrip <= 1'b0;
		conclude();
	end
endmodule : soft_start_accel_ramp_control_tb
